// File: fespc_pkg.sv
// constants and types of the flash command sequencer
package fespc_pkg;
	// ------------------------------------------------------------
	// instruction codes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_CHIP_A = 8'hC7;
	localparam logic [7:0] OP_CHIP_B = 8'h60;
	localparam logic [7:0] OP_SET = 8'h06;
	localparam logic [7:0] OP_CLR = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_WR_STAT = 8'h01;
	localparam logic [7:0] OP_RD_SUSP = 8'h07;
	localparam logic [7:0] OP_PAUSE_A = 8'h75;
	localparam logic [7:0] OP_PAUSE_B = 8'hB0;
	localparam logic [7:0] OP_CONT_A = 8'h7A;
	localparam logic [7:0] OP_CONT_B = 8'h30;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_SECT_A = 8'h20;
	localparam logic [7:0] OP_SECT_B = 8'hD7;
	localparam logic [7:0] OP_BLK_A = 8'h52;
	localparam logic [7:0] OP_BLK_B = 8'hD8;
	localparam logic [7:0] OP_PAGE = 8'h02;
	// ------------------------------------------------------------
	// frame lengths in serial clocks
	// ------------------------------------------------------------
	localparam logic [5:0] CNT_CODE = 6'h08;
	localparam logic [5:0] CNT_DATA = 6'h10;
	localparam logic [5:0] CNT_ADDR = 6'h20;
	localparam logic [5:0] CNT_PAGE = 6'h28;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	// ------------------------------------------------------------
	// register fields and reset values
	// ------------------------------------------------------------
	localparam int SR_BUSY = 0;
	localparam int SR_LATCH = 1;
	localparam int SR_QUAD = 6;
	localparam int FR_ERASE_PAUSED = 1;
	localparam int FR_PROG_PAUSED = 2;
	localparam logic [5:0] SR_NV_RESET = 6'h00;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int PAUSE_SETTLE_NS = 20000;
	localparam int PAUSE_SETTLE_CYC = PAUSE_SETTLE_NS * CLK_MHZ / 1000;
	localparam int SLEEP_ENTRY_NS = 3000;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS * CLK_MHZ / 1000;
	localparam int WAKE_RECOVERY_NS = 3000;
	localparam int WAKE_RECOVERY_CYC =
		(WAKE_RECOVERY_NS * CLK_MHZ + 999) / 1000;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_SETTLE, ST_PAUSED,
		ST_SLEEP_IN, ST_SLEEP, ST_WAKE} fespc_state_t;
	typedef enum logic [2:0] {K_NONE, K_CHIP, K_SECT, K_BLOCK, K_PAGE,
		K_STATUS} fespc_kind_t;
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] data;
		logic [5:0] cnt;
	} fespc_frame_t;
	typedef struct packed {
		logic sleep;
		logic [7:0] func;
		logic [7:0] status;
	} fespc_view_t;
endpackage

// File: fespc_ctrl.sv
// command sequencer of the serial flash: link side and control side
`timescale 1ns/1ps
`default_nettype none
module fespc_ctrl import fespc_pkg::*; #(
	parameter int CHIP_WIPE_CYC = 200000,
	parameter int SECTOR_WIPE_CYC = 50000,
	parameter int BLOCK_WIPE_CYC = 100000,
	parameter int PAGE_WRITE_CYC = 20000,
	parameter int STATUS_WRITE_CYC = 10000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	output logic [7:0] status_byte,
	output logic [7:0] func_byte,
	output logic sleeping,
	output logic busy_flag,
	output logic write_latch,
	output logic quad_io_enable
);
	// ------------------------------------------------------------
	// link side, clocked by the serial clock
	// ------------------------------------------------------------
	logic armed_reg; // high until the first edge of a frame
	logic [5:0] cnt_reg; // bits seen, saturating
	logic [5:0] cnt_next;
	logic [7:0] sr_reg; // last eight bits in
	logic [7:0] sr_next;
	logic [7:0] op_reg; // first byte of the frame
	logic tgl_reg; // flips once per frame
	fespc_view_t view_meta_reg; // control state, first stage
	fespc_view_t view_sync_reg; // control state, second stage
	logic [7:0] tx_reg; // byte being shifted out
	logic talk_reg; // this frame is a served read
	logic rd_ok; // opcode may be answered now
	logic [7:0] rd_val; // value to answer with
	logic so_reg;
	logic so_oe_reg;

	// frame start marker; select high holds it set, so a fresh
	// frame always starts counting at one
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			armed_reg <= 1'b1;
		end else begin
			armed_reg <= 1'b0;
		end
	end

	// bit counter and shifter, msb first on rising edges
	always_comb begin
		sr_next = {sr_reg[6:0], si};
		if (armed_reg) begin
			cnt_next = 6'h01;
		end else if (cnt_reg == CNT_MAX) begin
			cnt_next = CNT_MAX;
		end else begin
			cnt_next = cnt_reg + 6'h01;
		end
	end

	// frame capture; held after select rises so the control side
	// reads it as a quiet word once it sees the select edge
	always_ff @(posedge sclk) begin
		cnt_reg <= cnt_next;
		sr_reg <= sr_next;
		if (cnt_next == CNT_CODE) begin
			op_reg <= sr_next;
		end
	end

	// frame marker; a frame with no clocks is never executed
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			tgl_reg <= 1'b0;
		end else if (armed_reg) begin
			tgl_reg <= ~tgl_reg;
		end
	end

	// control state into the link domain; seven edges pass before
	// the answer byte is picked, so the chain is fresh by then
	always_ff @(posedge sclk) begin
		view_meta_reg <= {sleeping, func_byte, status_byte};
		view_sync_reg <= view_meta_reg;
	end

	// which reads are served: none asleep, only status while busy
	always_comb begin
		rd_ok = 1'b0;
		rd_val = view_sync_reg.status;
		if (!view_sync_reg.sleep) begin
			if (sr_next == OP_RD_STAT) begin
				rd_ok = 1'b1;
			end else if (sr_next == OP_RD_SUSP &&
				!view_sync_reg.status[SR_BUSY]) begin
				rd_ok = 1'b1;
				rd_val = view_sync_reg.func;
			end
		end
	end

	// answer byte; it repeats while the host keeps clocking
	always_ff @(posedge sclk) begin
		if (cnt_next == CNT_CODE) begin
			tx_reg <= rd_val;
		end else begin
			tx_reg <= {tx_reg[6:0], tx_reg[7]};
		end
	end

	// read phase flag, dropped as soon as select rises
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			talk_reg <= 1'b0;
		end else if (cnt_next == CNT_CODE) begin
			talk_reg <= rd_ok;
		end
	end

	// output changes on falling edges, half a clock ahead of the
	// host's sampling edge
	always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
		if (cs_n || rst) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end else begin
			so_reg <= tx_reg[7];
			so_oe_reg <= talk_reg;
		end
	end

	assign so = so_reg;
	assign so_oe = so_oe_reg;

	// ------------------------------------------------------------
	// crossing into the system clock
	// ------------------------------------------------------------
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic tgl_meta_reg;
	logic tgl_sync_reg;
	logic tgl_seen_reg;
	logic frame_end; // one cycle pulse per finished frame
	fespc_frame_t fr; // quiet frame word

	// select and frame marker each pass two flops
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			tgl_meta_reg <= 1'b0;
			tgl_sync_reg <= 1'b0;
			tgl_seen_reg <= 1'b0;
		end else begin
			cs_meta_reg <= cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
			tgl_meta_reg <= tgl_reg;
			tgl_sync_reg <= tgl_meta_reg;
			if (frame_end) begin
				tgl_seen_reg <= tgl_sync_reg;
			end
		end
	end

	// a command counts only when select rises after it
	assign frame_end = cs_sync_reg && !cs_prev_reg &&
		(tgl_sync_reg != tgl_seen_reg);
	assign fr = '{op: op_reg, data: sr_reg, cnt: cnt_reg};

	// ------------------------------------------------------------
	// decoding
	// ------------------------------------------------------------
	// suspend code, either form
	function automatic logic is_pause(input logic [7:0] op);
		is_pause = (op == OP_PAUSE_A) || (op == OP_PAUSE_B);
	endfunction

	// resume code, either form
	function automatic logic is_cont(input logic [7:0] op);
		is_cont = (op == OP_CONT_A) || (op == OP_CONT_B);
	endfunction

	// the erase and program kinds that may be suspended
	function automatic logic can_pause(input fespc_kind_t k);
		can_pause = (k == K_SECT) || (k == K_BLOCK) || (k == K_PAGE);
	endfunction

	// uninterrupted duration of each kind of work
	function automatic logic [31:0] dur(input fespc_kind_t k);
		unique case (k)
			K_CHIP: dur = 32'(CHIP_WIPE_CYC);
			K_SECT: dur = 32'(SECTOR_WIPE_CYC);
			K_BLOCK: dur = 32'(BLOCK_WIPE_CYC);
			K_PAGE: dur = 32'(PAGE_WRITE_CYC);
			K_STATUS: dur = 32'(STATUS_WRITE_CYC);
			K_NONE: dur = 32'h00000001;
		endcase
	endfunction

	fespc_state_t state_reg; // sequencer state
	fespc_kind_t kind_reg; // work in progress or paused
	logic [31:0] remain_reg; // cycles of work still to do
	logic [15:0] wait_reg; // settle, sleep and wake timer
	logic wel_reg; // write latch
	logic [5:0] nv_reg; // lock, quad and protect bits
	logic [5:0] pend_reg; // value for a status write
	logic erase_paused_flag_reg; // erase paused
	logic prog_paused_flag_reg; // program paused
	logic exact; // frame was the code alone
	fespc_kind_t start; // write work asked for, if any
	logic do_set;
	logic do_clr;
	logic do_pause;
	logic do_cont;
	logic do_sleep;
	logic do_wake;
	logic op_done; // last cycle of a write

	// command decode; all frames end up here, gated by state
	always_comb begin
		exact = fr.cnt == CNT_CODE;
		start = K_NONE;
		if (frame_end && state_reg == ST_IDLE && wel_reg) begin
			if (exact && (fr.op == OP_CHIP_A ||
				fr.op == OP_CHIP_B)) begin
				start = K_CHIP;
			end else if (fr.cnt >= CNT_ADDR && (fr.op == OP_SECT_A ||
				fr.op == OP_SECT_B)) begin
				start = K_SECT;
			end else if (fr.cnt >= CNT_ADDR && (fr.op == OP_BLK_A ||
				fr.op == OP_BLK_B)) begin
				start = K_BLOCK;
			end else if (fr.cnt >= CNT_PAGE && fr.op == OP_PAGE) begin
				start = K_PAGE;
			end else if (fr.cnt == CNT_DATA &&
				fr.op == OP_WR_STAT) begin
				start = K_STATUS;
			end
		end
		// latch codes only count when the device is idle
		do_set = frame_end && exact && fr.op == OP_SET &&
			state_reg == ST_IDLE;
		do_clr = frame_end && exact && fr.op == OP_CLR &&
			state_reg == ST_IDLE;
		// busy: only a suspend of a suspendable kind gets through
		do_pause = frame_end && exact && is_pause(fr.op) &&
			state_reg == ST_BUSY && can_pause(kind_reg);
		do_cont = frame_end && exact && is_cont(fr.op) &&
			state_reg == ST_PAUSED;
		do_sleep = frame_end && exact && fr.op == OP_SLEEP &&
			state_reg == ST_IDLE;
		// asleep, the wake code is the only one looked at
		do_wake = frame_end && fr.cnt >= CNT_CODE &&
			fr.op == OP_WAKE && state_reg == ST_SLEEP;
		op_done = state_reg == ST_BUSY && remain_reg == 32'h00000001;
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// state, remaining work and short waits; the remaining count is
	// frozen while paused, so the total never grows
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			kind_reg <= K_NONE;
			remain_reg <= 32'h00000000;
			wait_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start != K_NONE) begin
						state_reg <= ST_BUSY;
						kind_reg <= start;
						remain_reg <= dur(start);
					end else if (do_sleep) begin
						state_reg <= ST_SLEEP_IN;
						wait_reg <= 16'(SLEEP_ENTRY_CYC);
					end
				end
				ST_BUSY: begin
					if (do_pause) begin
						state_reg <= ST_SETTLE;
						wait_reg <= 16'(PAUSE_SETTLE_CYC);
					end else if (op_done) begin
						state_reg <= ST_IDLE;
						kind_reg <= K_NONE;
					end else begin
						remain_reg <= remain_reg - 32'h00000001;
					end
				end
				ST_SETTLE: begin
					// busy stays up, nothing accepted until ready
					if (wait_reg <= 16'h0001) begin
						state_reg <= ST_PAUSED;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
				ST_PAUSED: begin
					if (do_cont) begin
						state_reg <= ST_BUSY;
					end
				end
				ST_SLEEP_IN: begin
					if (wait_reg <= 16'h0001) begin
						state_reg <= ST_SLEEP;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
				ST_SLEEP: begin
					if (do_wake) begin
						state_reg <= ST_WAKE;
						wait_reg <= 16'(WAKE_RECOVERY_CYC);
					end
				end
				ST_WAKE: begin
					// frames in recovery are dropped, not queued
					if (wait_reg <= 16'h0001) begin
						state_reg <= ST_IDLE;
					end else begin
						wait_reg <= wait_reg - 16'h0001;
					end
				end
			endcase
		end
	end

	// write latch; completion and suspend both drop it
	always_ff @(posedge clk) begin
		if (rst) begin
			wel_reg <= 1'b0;
		end else if (op_done || do_pause || do_clr) begin
			wel_reg <= 1'b0;
		end else if (do_set) begin
			wel_reg <= 1'b1;
		end
	end

	// status bits; the new value lands when the write completes
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_reg <= SR_NV_RESET;
			pend_reg <= SR_NV_RESET;
		end else begin
			if (start == K_STATUS) begin
				pend_reg <= fr.data[7:2];
			end
			if (op_done && kind_reg == K_STATUS) begin
				nv_reg <= pend_reg;
			end
		end
	end

	// suspend flags, one for erase work (sector, block) and one for program work
	always_ff @(posedge clk) begin
		if (rst) begin
			erase_paused_flag_reg <= 1'b0;
			prog_paused_flag_reg <= 1'b0;
		end else if (do_pause) begin
			erase_paused_flag_reg <= kind_reg != K_PAGE;
			prog_paused_flag_reg <= kind_reg == K_PAGE;
		end else if (do_cont) begin
			erase_paused_flag_reg <= 1'b0;
			prog_paused_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// visible state, all from flops
	// ------------------------------------------------------------
	logic busy_now;
	assign busy_now = state_reg == ST_BUSY ||
		state_reg == ST_SETTLE;

	// one cycle behind the sequencer; also what the link answers
	always_ff @(posedge clk) begin
		if (rst) begin
			status_byte <= 8'h00;
			func_byte <= 8'h00;
			sleeping <= 1'b0;
		end else begin
			status_byte <= {nv_reg, wel_reg, busy_now};
			func_byte <= 8'h00;
			func_byte[FR_ERASE_PAUSED] <= erase_paused_flag_reg;
			func_byte[FR_PROG_PAUSED] <= prog_paused_flag_reg;
			sleeping <= state_reg == ST_SLEEP ||
				state_reg == ST_WAKE || state_reg == ST_SLEEP_IN;
		end
	end

	assign busy_flag = status_byte[SR_BUSY];
	assign write_latch = status_byte[SR_LATCH];
	assign quad_io_enable = status_byte[SR_QUAD];
endmodule
`default_nettype wire

// File: fespc_ctrl_sva.sv
// checker of the flash command sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fespc_ctrl_sva import fespc_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic [7:0] status_byte,
	input wire logic [7:0] func_byte,
	input wire logic sleeping,
	input wire logic busy_flag,
	input wire logic write_latch,
	input wire logic quad_io_enable
);
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	// small margin: the sync delay shifts when the pause takes effect
	localparam int SETTLE_MAX = PAUSE_SETTLE_CYC + 4;
	logic [11:0] settle_reg; // cycles busy while a pause flag is up
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// count settle cycles, saturating so it never wraps back to pass
	always_ff @(posedge clk) begin
		if (rst || !(busy_flag && func_byte != 8'h00)) begin
			settle_reg <= 12'h000;
		end else if (settle_reg != 12'hFFF) begin
			settle_reg <= settle_reg + 12'h001;
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_reset_clear;
		$fell(rst) |-> !write_latch && !busy_flag && func_byte == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not clear after reset");
	property p_status_map;
		busy_flag == status_byte[SR_BUSY] &&
			write_latch == status_byte[SR_LATCH] &&
			quad_io_enable == status_byte[SR_QUAD];
	endproperty
	a_status_map: assert property (p_status_map)
		else $error("status byte disagrees with flag ports");
	property p_done_clears;
		$fell(busy_flag) |-> !write_latch;
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("write latch left set after work");
	property p_start_needs_latch;
		$rose(busy_flag) && $past(func_byte) == 8'h00 |-> write_latch;
	endproperty
	a_start_needs_latch: assert property (p_start_needs_latch)
		else $error("work started without write latch");
	property p_paused_no_latch;
		func_byte != 8'h00 |-> !write_latch;
	endproperty
	a_paused_no_latch: assert property (p_paused_no_latch)
		else $error("write latch set while paused");
	property p_func_fields;
		func_byte[7:3] == 5'h00 && !func_byte[0] &&
			!(func_byte[FR_ERASE_PAUSED] && func_byte[FR_PROG_PAUSED]);
	endproperty
	a_func_fields: assert property (p_func_fields)
		else $error("suspend register has a bad field");
	property p_pause_busy;
		$rose(func_byte[FR_ERASE_PAUSED]) ||
			$rose(func_byte[FR_PROG_PAUSED]) |-> busy_flag;
	endproperty
	a_pause_busy: assert property (p_pause_busy)
		else $error("busy not held while pause settles");
	property p_settle_bound;
		settle_reg <= SETTLE_MAX;
	endproperty
	a_settle_bound: assert property (p_settle_bound)
		else $error("pause settle took too long");
	property p_resume_busy;
		$fell(func_byte[FR_ERASE_PAUSED]) ||
			$fell(func_byte[FR_PROG_PAUSED]) |-> busy_flag;
	endproperty
	a_resume_busy: assert property (p_resume_busy)
		else $error("work not restarted on continue");
	property p_sleep_quiet;
		sleeping |-> !so_oe && !busy_flag;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("device active while asleep");
	property p_select_idle;
		cs_n [*2] |-> !so_oe;
	endproperty
	a_select_idle: assert property (p_select_idle)
		else $error("output driven while deselected");
	property p_sleep_hold;
		$rose(sleeping) |=> sleeping [*8];
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("sleep entry dropped early");
endmodule
bind fespc_ctrl fespc_ctrl_sva chk_i (.clk(clk), .rst(rst), .sclk(sclk),
	.cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
	.status_byte(status_byte), .func_byte(func_byte), .sleeping(sleeping),
	.busy_flag(busy_flag), .write_latch(write_latch),
	.quad_io_enable(quad_io_enable));
`default_nettype wire

// File: fespc_host_model.sv
// host side of the serial link: framing, link clock and data
`timescale 1ns/1ps
`default_nettype none
module fespc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	// ------------------------------------------------------------
	// link state
	// ------------------------------------------------------------
	localparam int HALF_NS = 40; // half of the 80 ns link clock
	logic oe_seen; // so_oe seen high during the last frame
	// idle: clock stands still, device deselected
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b1;
		oe_seen = 1'b0;
	end
	// one frame of n bits taken from the top of bits, msb first
	task automatic xfer(input logic [39:0] bits, input int n,
		output logic [7:0] rx);
		rx = 8'h00;
		oe_seen = 1'b0;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = bits[39 - i];
			#HALF_NS sclk = 1'b1;
			rx = {rx[6:0], so}; // sampled on the rising edge
			oe_seen = oe_seen | so_oe;
			#HALF_NS sclk = 1'b0;
		end
		#HALF_NS cs_n = 1'b1;
		si = ~si; // a released line must not show the last bit
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench import fespc_pkg::*;;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int WORK = 1000; // long enough to pause mid-work
	logic clk, rst, sclk, cs_n, si, so, so_oe;
	logic sleeping, busy_flag, write_latch, quad_io_enable;
	logic [7:0] status_byte, func_byte, rx;
	int error_cnt, checked, k;
	initial clk = 1'b0;
	always #5 clk = ~clk;
	fespc_ctrl #(.CHIP_WIPE_CYC(WORK), .SECTOR_WIPE_CYC(WORK),
		.BLOCK_WIPE_CYC(50), .PAGE_WRITE_CYC(WORK),
		.STATUS_WRITE_CYC(50)) dut (.clk(clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.status_byte(status_byte), .func_byte(func_byte),
		.sleeping(sleeping), .busy_flag(busy_flag),
		.write_latch(write_latch), .quad_io_enable(quad_io_enable));
	fespc_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// frame then room for the synchronised command to act
	task automatic op(input logic [7:0] code, input int n,
		input logic [7:0] data);
		host.xfer({code, data, 24'h000000}, n, rx);
		wait_clk(10);
	endtask
	// bounded poll of busy; k returns the cycles spent
	task automatic busy_wait(input int limit);
		k = 0;
		while (busy_flag !== 1'b0 && k < limit) begin
			wait_clk(1);
			k++;
		end
	endtask
	task automatic stop_test;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_latch;
		chk("latch at reset", write_latch, 1'b0);
		op(OP_SET, 9, 8'h00); // one bit too many
		chk("latch long frame", write_latch, 1'b0);
		op(OP_SET, 8, 8'h00);
		chk("latch set", write_latch, 1'b1);
		op(OP_RD_STAT, 16, 8'h00);
		chk("status read", rx, 8'h02);
		op(OP_CLR, 8, 8'h00);
		chk("latch clear", write_latch, 1'b0);
		$display("test latch done");
	endtask
	task automatic t_chip;
		logic [7:0] codes [2];
		codes = '{OP_CHIP_A, OP_CHIP_B};
		op(OP_CHIP_A, 8, 8'h00);
		chk("erase without latch", busy_flag, 1'b0);
		foreach (codes[i]) begin
			op(OP_SET, 8, 8'h00);
			op(codes[i], 16, 8'h00);
			chk("erase long frame", busy_flag, 1'b0);
			op(codes[i], 8, 8'h00);
			chk("erase busy", busy_flag, 1'b1);
			op(OP_CLR, 8, 8'h00);
			chk("clear while busy", write_latch, 1'b1);
			op(OP_RD_STAT, 16, 8'h00);
			chk("status while busy", rx, 8'h03);
			op(OP_PAUSE_A, 8, 8'h00); // whole-array work cannot pause
			chk("pause chip erase", func_byte, 8'h00);
			busy_wait(WORK);
			chk("erase done", busy_flag, 1'b0);
			chk("latch after erase", write_latch, 1'b0);
		end
		$display("test chip erase done");
	endtask
	task automatic t_status_write_cmd;
		op(OP_SET, 8, 8'h00);
		op(OP_WR_STAT, 16, 8'h43); // low two bits are dropped
		busy_wait(200);
		chk("status written", status_byte, 8'h40);
		op(OP_WR_STAT, 16, 8'h00);
		chk("write without latch", quad_io_enable, 1'b1);
		op(OP_SET, 8, 8'h00);
		op(OP_WR_STAT, 16, 8'h00);
		busy_wait(200);
		chk("quad disabled", quad_io_enable, 1'b0);
		$display("test status write done");
	endtask
	// block erase in both forms and the second sector code; a frame
	// cut short in the address is refused and leaves the latch set
	task automatic t_block;
		logic [7:0] codes [3];
		codes = '{OP_BLK_A, OP_BLK_B, OP_SECT_B};
		foreach (codes[i]) begin
			op(OP_SET, 8, 8'h00);
			op(codes[i], 24, 8'h00);
			chk("erase short frame", busy_flag, 1'b0);
			chk("latch kept", write_latch, 1'b1);
			op(codes[i], 32, 8'h00);
			chk("erase started", busy_flag, 1'b1);
			busy_wait(WORK + 100);
			chk("erase finished", busy_flag, 1'b0);
			chk("latch after erase", write_latch, 1'b0);
		end
		$display("test block erase done");
	endtask
	task automatic t_pause(input logic [7:0] code, input int n,
		input logic [7:0] pause, input logic [7:0] cont,
		input logic [7:0] flag);
		op(OP_SET, 8, 8'h00);
		op(code, n, 8'h00);
		chk("work busy", busy_flag, 1'b1);
		wait_clk(50);
		op(pause, 8, 8'h00);
		chk("pause flag", func_byte, flag);
		chk("latch on pause", write_latch, 1'b0);
		op(OP_SET, 8, 8'h00);
		chk("set while settling", write_latch, 1'b0);
		busy_wait(PAUSE_SETTLE_CYC + 100);
		chk("settle bound", k < PAUSE_SETTLE_CYC, 1'b1);
		op(OP_SET, 8, 8'h00);
		chk("set while paused", write_latch, 1'b0);
		op(OP_RD_SUSP, 16, 8'h00);
		chk("suspend read", rx, flag);
		op(OP_RD_STAT, 16, 8'h00);
		chk("status paused", rx, 8'h00);
		op(cont, 8, 8'h00);
		chk("flag after continue", func_byte, 8'h00);
		chk("busy after continue", busy_flag, 1'b1);
		busy_wait(WORK);
		chk("rest of work", k < WORK - 100, 1'b1);
		chk("latch after work", write_latch, 1'b0);
		$display("test pause done");
	endtask
	task automatic t_sleep;
		op(OP_SLEEP, 16, 8'h00);
		chk("sleep long frame", sleeping, 1'b0);
		op(OP_SLEEP, 8, 8'h00);
		chk("sleep entry", sleeping, 1'b1);
		wait_clk(SLEEP_ENTRY_CYC);
		op(OP_RD_STAT, 16, 8'h00);
		chk("read asleep", host.oe_seen, 1'b0);
		op(OP_SET, 8, 8'h00);
		chk("set asleep", write_latch, 1'b0);
		op(OP_WAKE, 8, 8'h00);
		wait_clk(WAKE_RECOVERY_CYC);
		chk("awake", sleeping, 1'b0);
		op(OP_SET, 8, 8'h00);
		chk("set after wake", write_latch, 1'b1);
		$display("test sleep done");
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		error_cnt = 0;
		checked = 0;
		k = 0;
		// a real edge after time zero, so the link side's
		// asynchronous resets cannot miss it
		rst = 1'b0;
		#1 rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wait_clk(2);
		t_latch;
		t_chip;
		t_status_write_cmd;
		t_block;
		t_pause(OP_SECT_A, 32, OP_PAUSE_A, OP_CONT_A, 8'h02);
		t_pause(OP_PAGE, 40, OP_PAUSE_B, OP_CONT_B, 8'h04);
		t_sleep;
		stop_test;
	end
	// a hang ends the run with a mismatch counted
	initial begin
		#800000;
		error_cnt++;
		$display("ERROR watchdog expected done seen hang");
		stop_test;
	end
endmodule
`default_nettype wire
